// ---- opm_defines.svh ----
/*
  Constants for the one-time-programmable memory access port: register
  offsets, field positions, reset values and timing counts.
  Assumes a 250 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef OPM_DEFINES_SVH
`define OPM_DEFINES_SVH

`define OPM_CLK_MHZ          250
`define OPM_ADDR_SETUP_US    2
`define OPM_ADDR_SETUP_CYC   (`OPM_ADDR_SETUP_US * `OPM_CLK_MHZ)
`define OPM_PULSE_MIN_NS     950
`define OPM_PULSE_MIN_CYC    ((`OPM_PULSE_MIN_NS * `OPM_CLK_MHZ + 999) / 1000)

`define OPM_MEM_WORDS        8192
`define OPM_SMALL_LIMIT      16'h1000
`define OPM_LARGE_LIMIT      16'h2000
`define OPM_SIZE_SEL_ADDR    13'h0003
`define OPM_PROT_RAM_BASE    8'h80
`define OPM_CFG_REG_BASE     8'hf0
`define OPM_INT_MASK_ARM_BIT 6

`define OPM_REG_STATUS       8'h00
`define OPM_REG_FETCH        8'h04
`define OPM_REG_RAMCHK       8'h08
`define OPM_REG_INT_MASK     8'h0c

`define OPM_ST_MEM_PROT      0
`define OPM_ST_RAM_PROT      1
`define OPM_ST_SMALL         2
`define OPM_ST_PROG_MODE     3
`define OPM_INT_MASK_RESET   8'h00

`define OPM_RESP_OKAY        2'b00
`define OPM_RESP_SLVERR      2'b10

`endif

// ---- opm_pkg.sv ----
/*
  Types used by the programming port; its pulse timer does not use them.
  Assumes opm_defines.svh is included by the users of the constants.
*/
package opm_pkg;
  typedef enum logic [2:0] {
    OPM_IDLE    = 3'b000,
    OPM_READ    = 3'b001,
    OPM_PROGRAM = 3'b010,
    OPM_VERIFY  = 3'b011,
    OPM_OPTION  = 3'b100
  } opm_mode_e;
  typedef logic [12:0] opm_addr_t;
endpackage : opm_pkg

// ---- opm_port.sv ----
/*
  One-time-programmable program store and its external programming port,
  with protect, RAM-protect and size options, fetch strobe decode and an
  AXI4-Lite status window.
  Assumes pins are asynchronous to clk and the high-voltage detector
  presents mode entry as a logic level; supply levels are outside logic.
*/
// Summary of operation
// RULE1: Read mode outputs stored bytes like ROM.
// RULE2: After protect, read data is not valid.
// RULE3: Programmer pulses 1 ms, at most 25.
// RULE4: Programmer overprograms three times accumulated time.
// RULE5: Programmer reads back all data at end.
// RULE6: Verify returns stored data while programming voltage.
// RULE7: Protect blocks read, verify and program.
// RULE8: RAM protect with mask bit blocks upper registers.
// RULE9: Fetch strobe above 4096 small, 8192 large.
// RULE10: Small option makes upper four kilobytes unusable.
// RULE11: Programmer presents address 03 for size select.
// RULE12: Unprogrammed size option means large memory.
// RULE13: Option pulses last at most 78.75 ms.
// RULE14: Address valid 2 us before output gate.
// RULE15: Programmer counts pulses and records failures.
// RULE16: Without high voltage, port ignored, normal mode.
`timescale 1ns/1ns
`include "opm_defines.svh"
module opm_port (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        eprom_mode_entry,
  input  wire logic        chip_enable_n,
  input  wire logic        output_gate_n,
  input  wire logic        program_strobe_n,
  input  wire logic        vpp_on,
  input  wire logic [12:0] prog_addr,
  input  wire logic [7:0]  data_i,
  output logic      [7:0]  data_o,
  output logic             data_oe,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        fetch_req,
  output logic             external_fetch_strobe_n,
  output logic             fetch_internal,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // An unburnt cell reads as ones, so the store starts erased.
  logic [7:0]         mem [0:`OPM_MEM_WORDS-1] = '{default: 8'hff};
  logic [4:0]         s1_reg;
  logic [4:0]         s2_reg;
  logic [12:0]        a1_reg;
  logic [12:0]        a2_reg;
  logic [12:0]        a3_reg;
  logic [7:0]         d1_reg;
  logic [7:0]         d2_reg;
  logic               mem_prot_reg;
  logic               ram_prot_reg;
  logic               small_reg;
  logic               opt_pulse_reg;
  logic [7:0]         interrupt_mask_register_reg;
  logic [7:0]         ramchk_reg;
  logic               ramchk_blocked_reg;
  logic [9:0]         oe_wait_reg;
  opm_pkg::opm_mode_e mode;
  logic               hv;
  logic               ce;
  logic               oe;
  logic               pg;
  logic               vpp;
  opm_pulse_if        pif ();

  opm_pulse_timer i_opm_pulse_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pif     (pif)
  );

  // Every pin passes two flops, the address a third; the second stage is read, the third only by the setup counter.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
      a1_reg <= 13'h0000;
      a2_reg <= 13'h0000;
      a3_reg <= 13'h0000;
      d1_reg <= 8'h00;
      d2_reg <= 8'h00;
    end else begin
      s1_reg <= {eprom_mode_entry, ~chip_enable_n, ~output_gate_n, ~program_strobe_n, vpp_on};
      s2_reg <= s1_reg;
      a1_reg <= prog_addr;
      a2_reg <= a1_reg;
      a3_reg <= a2_reg;
      d1_reg <= data_i;
      d2_reg <= d1_reg;
    end
  end
  assign hv  = s2_reg[4];
  assign ce  = s2_reg[3];
  assign oe  = s2_reg[2];
  assign pg  = s2_reg[1];
  assign vpp = s2_reg[0];

  function automatic opm_pkg::opm_mode_e decode_mode(input logic h, input logic c, input logic o,
                                                     input logic p, input logic v);
    if (!h) begin
      decode_mode = opm_pkg::OPM_IDLE; // RULE16
    end else if (c && o && !p) begin
      decode_mode = v ? opm_pkg::OPM_VERIFY : opm_pkg::OPM_READ; // RULE1 RULE6
    end else if (c && !o && p && v) begin
      decode_mode = opm_pkg::OPM_PROGRAM;
    end else if (!c && !o && p && v) begin
      decode_mode = opm_pkg::OPM_OPTION;
    end else begin
      decode_mode = opm_pkg::OPM_IDLE;
    end
  endfunction : decode_mode

  assign mode = decode_mode(hv, ce, oe, pg, vpp);
  assign pif.strobe_on = (mode == opm_pkg::OPM_PROGRAM) || (mode == opm_pkg::OPM_OPTION);

  // Measures how long the address has stood still; it only feeds coverage and never gates data.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_wait_reg <= 10'h000;
    end else if (!hv || a2_reg != a3_reg) begin
      oe_wait_reg <= 10'h000;
    end else if (oe_wait_reg != 10'(`OPM_ADDR_SETUP_CYC)) begin
      oe_wait_reg <= oe_wait_reg + 10'h001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_o  <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_oe <= (mode == opm_pkg::OPM_READ) || (mode == opm_pkg::OPM_VERIFY); // RULE1 RULE6
      if (mem_prot_reg) begin
        data_o <= 8'hff; // RULE2 RULE7
      end else begin
        data_o <= mem[a2_reg];
      end
    end
  end

  // A cell only ever loses erased ones, so programming is a bitwise AND.
  always_ff @(posedge clk) begin
    if (pif.pulse_done && mode == opm_pkg::OPM_IDLE && !mem_prot_reg && hv && !opt_pulse_reg) begin
      mem[a2_reg] <= mem[a2_reg] & d2_reg; // RULE7
    end
  end

  // Remembers the kind of the last strobe, so an option pulse never burns
  // the store and a program pulse never sets an option.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      opt_pulse_reg <= 1'b0;
    end else if (mode == opm_pkg::OPM_OPTION) begin
      opt_pulse_reg <= 1'b1;
    end else if (mode == opm_pkg::OPM_PROGRAM) begin
      opt_pulse_reg <= 1'b0;
    end
  end

  // The option fuses are set by a completed option pulse and clear only on sys_rst.
  // Chip enable released at strobe end picks memory protect; held picks size or RAM protect.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_prot_reg <= 1'b0;
      ram_prot_reg <= 1'b0;
      small_reg    <= 1'b0; // RULE12
    end else if (pif.pulse_done && hv && opt_pulse_reg && !oe) begin
      if (!ce) begin
        mem_prot_reg <= 1'b1; // RULE7
      end else if (a2_reg == `OPM_SIZE_SEL_ADDR) begin
        small_reg <= 1'b1;
      end else begin
        ram_prot_reg <= 1'b1; // RULE8
      end
    end
  end

  always_comb begin
    fetch_internal          = 1'b0;
    external_fetch_strobe_n = 1'b1;
    if (fetch_req) begin
      if (small_reg) begin
        fetch_internal = fetch_addr < `OPM_SMALL_LIMIT; // RULE9 RULE10
      end else begin
        fetch_internal = fetch_addr < `OPM_LARGE_LIMIT; // RULE9 RULE12
      end
      external_fetch_strobe_n = fetch_internal;
    end
  end

  // Register bus: one write and one read in flight; response follows both halves.
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [7:0]  aw_reg;
  logic [31:0] w_reg;
  logic [3:0]  ws_reg;

  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      aw_reg     <= 8'h00;
      w_reg      <= 32'h00000000;
      ws_reg     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_reg     <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_reg     <= s_axi_wdata;
        ws_reg    <= s_axi_wstrb;
      end
      if (aw_got_reg && w_got_reg) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
      end
    end
  end

  logic wr_fire;
  logic ram_block;
  assign wr_fire = aw_got_reg && w_got_reg;
  assign ram_block = ram_prot_reg && interrupt_mask_register_reg[`OPM_INT_MASK_ARM_BIT];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= `OPM_RESP_OKAY;
      interrupt_mask_register_reg <= `OPM_INT_MASK_RESET;
      ramchk_reg         <= 8'h00;
      ramchk_blocked_reg <= 1'b0;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `OPM_RESP_OKAY;
        unique case (aw_reg)
          `OPM_REG_INT_MASK: begin
            if (ws_reg[0]) begin
              interrupt_mask_register_reg <= w_reg[7:0];
            end
          end
          `OPM_REG_RAMCHK: begin
            if (ws_reg[0]) begin
              ramchk_reg <= w_reg[7:0];
              // Upper register bank is refused, mode and configuration registers excepted.
              ramchk_blocked_reg <= ram_block && w_reg[7:0] >= `OPM_PROT_RAM_BASE
                                    && w_reg[7:0] < `OPM_CFG_REG_BASE; // RULE8
            end
          end
          `OPM_REG_STATUS, `OPM_REG_FETCH: begin
          end
          default: s_axi_bresp <= `OPM_RESP_SLVERR;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `OPM_RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `OPM_RESP_OKAY;
        s_axi_rdata  <= 32'h00000000;
        unique case (s_axi_araddr[7:0])
          `OPM_REG_STATUS: s_axi_rdata <= {28'h0000000, hv, small_reg, ram_prot_reg, mem_prot_reg};
          `OPM_REG_FETCH:  s_axi_rdata <= {16'h0000, small_reg ? `OPM_SMALL_LIMIT : `OPM_LARGE_LIMIT};
          `OPM_REG_RAMCHK: s_axi_rdata <= {23'h000000, ramchk_blocked_reg, ramchk_reg};
          `OPM_REG_INT_MASK: s_axi_rdata <= {24'h000000, interrupt_mask_register_reg};
          default:         s_axi_rresp <= `OPM_RESP_SLVERR;
        endcase
      end
    end
  end

  read_out_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    mode == opm_pkg::OPM_READ |=> data_oe) else $error("read mode without output drive");
  prot_data_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    $past(mem_prot_reg) |-> data_o == 8'hff) else $error("protected store leaked data");
  prot_sticky_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    $rose(mem_prot_reg) |=> mem_prot_reg [*8]) else $error("protect fuse cleared");
  verify_out_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    mode == opm_pkg::OPM_VERIFY |=> data_oe) else $error("verify without output drive");
  small_fetch_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
    fetch_req && small_reg && fetch_addr >= 16'h1000 |-> !external_fetch_strobe_n)
    else $error("small size fetch stayed internal");
  large_fetch_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    fetch_req && !small_reg && fetch_addr < 16'h2000 |-> external_fetch_strobe_n)
    else $error("large size fetch went external");
  no_hv_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    !hv |=> !data_oe) else $error("port active without high voltage");
  ram_block_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    wr_fire && aw_reg == `OPM_REG_RAMCHK && ws_reg[0] && !ram_block |=> !ramchk_blocked_reg)
    else $error("register access blocked without protect");
  upper_unused_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
    small_reg && fetch_req && fetch_addr[15:12] == 4'h1 |-> !fetch_internal)
    else $error("upper bank used in small size");

  read_cov: cover property (@(posedge clk) disable iff (sys_rst) mode == opm_pkg::OPM_READ ##1 data_oe);
  prog_cov: cover property (@(posedge clk) disable iff (sys_rst) pif.pulse_done && mode == opm_pkg::OPM_IDLE);
  prot_cov: cover property (@(posedge clk) disable iff (sys_rst) $rose(mem_prot_reg));
  size_cov: cover property (@(posedge clk) disable iff (sys_rst) $rose(small_reg));
  setup_cov: cover property (@(posedge clk) disable iff (sys_rst) oe && oe_wait_reg == 10'(`OPM_ADDR_SETUP_CYC));
endmodule : opm_port

// ---- opm_port_tb_top.sv ----
/*
  Self-checking bench for the OTP port: status window, fetch decode and pins.
  Assumes the store starts erased to all ones and a 250 MHz clock.
*/
`timescale 1ns/1ns
`include "opm_defines.svh"
module opm_port_tb_top;
  localparam int         LIMIT = 80000;
  localparam logic [1:0] OK    = `OPM_RESP_OKAY;
  localparam logic [1:0] ERR   = `OPM_RESP_SLVERR;
  logic        clk, sys_rst, fetch_req, data_oe, external_fetch_strobe_n, fetch_internal;
  logic        eprom_mode_entry, chip_enable_n, output_gate_n, program_strobe_n, vpp_on;
  logic [12:0] prog_addr;
  logic [7:0]  data_i, data_o;
  logic [15:0] fetch_addr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q[$];
  logic [12:0] pa[4];
  logic [7:0]  pd[4];
  logic [8:0]  q;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0, np;

  opm_port i_opm_port (.*);
  opm_prog_model i_opm_prog_model (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // Ready is combinational, so it is sampled mid-cycle and acted on at the next edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ah, wh, bh;
    bh = 1'b0;
    exp_q.push_back({r, 32'h0});
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {24'h0, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!bh) begin
      @(negedge clk);
      {ah, wh, bh} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
      @(posedge clk);
      {s_axi_awvalid, s_axi_wvalid} <= {s_axi_awvalid & ~ah, s_axi_wvalid & ~wh};
    end
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ah, rh;
    rh = 1'b0;
    exp_q.push_back({r, d});
    @(posedge clk);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (!rh) begin
      @(negedge clk);
      {ah, rh} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
      @(posedge clk);
      s_axi_arvalid <= s_axi_arvalid & ~ah;
    end
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      results();
    end
    if (!sys_rst && s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (!sys_rst && s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, exp_q.pop_front());
  end

  task automatic fchk(input logic [15:0] a, input logic [15:0] lim, input logic r);
    @(posedge clk);
    {fetch_req, fetch_addr} <= {r, a};
    @(negedge clk);
    check({32'h0, external_fetch_strobe_n, fetch_internal}, {32'h0, !r || a < lim, r && a < lim});
  endtask : fchk

  task automatic ram_chk(input logic armed);
    logic [7:0] ra[5] = '{8'h7f, 8'h80, 8'hc5, 8'hef, 8'hf0};
    for (int i = 0; i < 5; i++) begin
      axi_wr(`OPM_REG_RAMCHK, {24'h0, ra[i]}, OK);
      axi_rd(`OPM_REG_RAMCHK, {23'h0, armed && ra[i] >= `OPM_PROT_RAM_BASE && ra[i] < `OPM_CFG_REG_BASE, ra[i]}, OK);
    end
  endtask : ram_chk

  initial begin
    sys_rst = 1'b1;
    {fetch_req, fetch_addr} = 17'h10000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h47e487d9));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    axi_rd(`OPM_REG_STATUS, 32'h0, OK);
    axi_rd(`OPM_REG_FETCH, 32'h2000, OK);
    axi_rd(`OPM_REG_INT_MASK, 32'h0, OK);
    axi_rd(8'h10, 32'h0, ERR);
    axi_wr(8'h14, 32'h0, ERR);
    for (int i = 0; i < 8; i++) fchk(i < 2 ? 16'h1fff + 16'(i) : 16'($urandom), 16'h2000, (i % 3) != 2);
    i_opm_prog_model.pulse(13'h1ffe, 8'h00, 1'b0, 250, 1'b0);
    i_opm_prog_model.read_byte(13'h1ffe, 1'b0, q);
    check({33'h0, q[8]}, 34'h0);
    i_opm_prog_model.set_hv(1'b1);
    axi_rd(`OPM_REG_STATUS, 32'h8, OK);
    foreach (pa[i]) begin
      pa[i] = 13'(i * 1024 + $urandom_range(1023));
      pd[i] = 8'($urandom);
      i_opm_prog_model.program_byte(pa[i], pd[i], np);
      check(34'(np), 34'h1);
    end
    foreach (pa[i]) begin
      i_opm_prog_model.read_byte(pa[i], 1'b0, q);
      check({25'h0, q}, {26'h1, pd[i]});
    end
    i_opm_prog_model.read_byte(13'h1ffe, 1'b0, q);
    check({25'h0, q}, 34'h1ff);
    i_opm_prog_model.read_byte(pa[0], 1'b1, q);
    check({25'h0, q}, {26'h1, pd[0]});
    axi_wr(`OPM_REG_INT_MASK, 32'h40, OK);
    axi_rd(`OPM_REG_INT_MASK, 32'h40, OK);
    ram_chk(1'b0);
    i_opm_prog_model.pulse(13'h0005, 8'h00, 1'b1, 300, 1'b0);
    axi_rd(`OPM_REG_STATUS, 32'ha, OK);
    ram_chk(1'b1);
    axi_wr(`OPM_REG_INT_MASK, 32'h0, OK);
    ram_chk(1'b0);
    i_opm_prog_model.pulse(13'h0003, 8'h00, 1'b1, 300, 1'b0);
    axi_rd(`OPM_REG_STATUS, 32'he, OK);
    axi_rd(`OPM_REG_FETCH, 32'h1000, OK);
    for (int i = 0; i < 8; i++) fchk(i < 2 ? 16'h0fff + 16'(i) : 16'($urandom_range(16'h2000)), 16'h1000, (i % 3) != 2);
    i_opm_prog_model.pulse(13'h0000, 8'h00, 1'b1, 300, 1'b1);
    axi_rd(`OPM_REG_STATUS, 32'hf, OK);
    i_opm_prog_model.read_byte(pa[1], 1'b0, q);
    check({25'h0, q}, 34'h1ff);
    i_opm_prog_model.program_byte(pa[2], 8'h00, np);
    check(34'(np), 34'h19);
    check(34'(i_opm_prog_model.fail_count), 34'h1);
    results();
  end
endmodule : opm_port_tb_top

// ---- opm_prog_model.sv ----
/*
  Behavioural programmer on the far side of the OTP port pins.
  Assumes the shared core clock; pulse units are shortened to cycles.
*/
`timescale 1ns/1ns
module opm_prog_model #(
  parameter int PULSE_CYC  = 250,
  parameter int SETUP_CYC  = 500,
  parameter int MAX_PULSES = 25
) (
  input  wire logic       clk,
  output logic            eprom_mode_entry,
  output logic            chip_enable_n,
  output logic            output_gate_n,
  output logic            program_strobe_n,
  output logic            vpp_on,
  output logic [12:0]     prog_addr,
  output logic [7:0]      data_i,
  input  wire logic [7:0] data_o,
  input  wire logic       data_oe
);
  int fail_count = 0;

  initial begin
    {eprom_mode_entry, vpp_on} = 2'b00;
    {chip_enable_n, output_gate_n, program_strobe_n} = 3'b111;
    {prog_addr, data_i} = 21'h0000a5;
  end

  task automatic set_hv(input logic v);
    @(posedge clk);
    eprom_mode_entry <= v;
    repeat (4) @(posedge clk);
  endtask : set_hv

  // Returns {data_oe, data_o} so a caller can also see an undriven bus.
  task automatic read_byte(input logic [12:0] a, input logic v, output logic [8:0] q);
    @(posedge clk);
    {chip_enable_n, program_strobe_n, vpp_on} <= {2'b01, v};
    prog_addr <= a;
    repeat (SETUP_CYC) @(posedge clk);
    output_gate_n <= 1'b0;
    for (int k = 0; k < 20 && data_oe !== 1'b1; k++) @(posedge clk);
    @(posedge clk);
    q = {data_oe, data_o};
    {output_gate_n, chip_enable_n} <= 2'b11;
  endtask : read_byte

  // The chip enable level at strobe end picks which option an option pulse sets.
  task automatic pulse(input logic [12:0] a, input logic [7:0] d, input logic ce_n, input int n,
                       input logic ce_end);
    @(posedge clk);
    {chip_enable_n, output_gate_n, vpp_on} <= {ce_n, 2'b11};
    {prog_addr, data_i} <= {a, d};
    repeat (SETUP_CYC) @(posedge clk);
    program_strobe_n <= 1'b0;
    repeat (n) @(posedge clk);
    {program_strobe_n, chip_enable_n} <= {1'b1, ce_end};
    repeat (8) @(posedge clk);
    {chip_enable_n, data_i} <= {1'b1, ~d};
  endtask : pulse

  task automatic program_byte(input logic [12:0] a, input logic [7:0] d, output int n);
    logic [8:0] q;
    n = 0;
    q = {1'b0, ~d};
    while (q !== {1'b1, d} && n < MAX_PULSES) begin
      pulse(a, d, 1'b0, PULSE_CYC, 1'b0);
      n++;
      read_byte(a, 1'b1, q);
    end
    if (q === {1'b1, d}) begin
      pulse(a, d, 1'b0, 3 * n * PULSE_CYC, 1'b0);
    end else begin
      fail_count++;
    end
  endtask : program_byte
endmodule : opm_prog_model

// ---- opm_pulse_if.sv ----
/*
  Carries a strobe level and its qualified-pulse result between the port
  and its pulse timer. Assumes one clock domain.
*/
`timescale 1ns/1ns
interface opm_pulse_if;
  logic strobe_on;
  logic pulse_done;
  modport port  (output strobe_on, input pulse_done);
  modport timer (input strobe_on, output pulse_done);
endinterface : opm_pulse_if

// ---- opm_pulse_timer.sv ----
/*
  Measures a program strobe and reports a pulse long enough to count as a
  program pulse when the strobe ends. Assumes synchronised strobe input.
*/
`timescale 1ns/1ns
`include "opm_defines.svh"
module opm_pulse_timer (
  input wire logic clk,
  input wire logic sys_rst,
  opm_pulse_if.timer pif
);
  logic [17:0] cnt_reg;
  logic        long_reg;
  logic        done_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg  <= 18'h00000;
      long_reg <= 1'b0;
    end else if (pif.strobe_on) begin
      cnt_reg <= cnt_reg + 18'h00001;
      if (cnt_reg >= 18'(`OPM_PULSE_MIN_CYC - 1)) begin
        long_reg <= 1'b1;
      end
    end else begin
      cnt_reg  <= 18'h00000;
      long_reg <= 1'b0;
    end
  end

  // A short glitch on the strobe must not burn a cell, so only full pulses count.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= long_reg && !pif.strobe_on;
    end
  end
  assign pif.pulse_done = done_reg;

  pulse_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    pif.pulse_done |-> $past(long_reg)) else $error("pulse reported without full width");
endmodule : opm_pulse_timer
